// file: verilog/bdm_data_memory.v
// banked data memory, core registers and status register
// assumes core datapath on clk gives one request per cycle
`timescale 1ns/1ps
`default_nettype none
`include "bdm_regs.vh"
module bdm_data_memory (
  input  wire        clk,
  input  wire        arst_n,
  input  wire        req,
  input  wire        wr,
  input  wire [1:0]  mode,
  input  wire [6:0]  offset,
  input  wire [7:0]  wdata,
  input  wire [2:0]  alu_op,
  input  wire [7:0]  op_a,
  input  wire [7:0]  op_b,
  input  wire        alu_cin,
  input  wire        wdt_clear,
  input  wire        sleep_exec,
  input  wire        wdt_timeout,
  input  wire [7:0]  prog_rdata,
  output reg  [7:0]  rdata,
  output reg         rvalid,
  output reg         prog_req,
  output reg  [14:0] prog_addr,
  output reg  [7:0]  alu_result,
  output reg  [7:0]  status,
  output reg  [4:0]  bank_select,
  output reg  [7:0]  periph_addr_dummy
);
////////////////////////////////////////////////////////////////////////////
// mode 0 direct, 1 via pointer zero, 2 via pointer one
reg  [7:0]  ptr0l;
reg  [7:0]  ptr0h;
reg  [7:0]  ptr1l;
reg  [7:0]  ptr1h;
reg  [7:0]  working_accumulator;
reg  [7:0]  program_counter_low;
reg  [7:0]  program_counter_latch_high;
reg  [7:0]  interrupt_control;
reg  [7:0]  gpr_mem [0:`BDM_GPR_DEPTH-1];
reg  [7:0]  com_mem [0:15];
reg         prog_wait;
reg  [7:0]  next_status;
reg  [8:0]  sum;
reg  [4:0]  nib;
reg  [7:0]  b_eff;
reg  [15:0] ptr;
reg  [11:0] addr;
reg         lin;
reg         prog_sel;
reg  [11:0] gidx;
reg         gpr_hit;
reg         com_hit;
reg         core_hit;
reg  [7:0]  rd_mux;
reg  [7:0]  lin_ofs;
reg  [15:0] lin_off;
wire [6:0]  ofs;
wire [4:0]  bnk;
////////////////////////////////////////////////////////////////////////////
// address forming
always @* begin
  ptr = (mode == 2'd2) ? {ptr1h, ptr1l} : {ptr0h, ptr0l};
  prog_sel = (mode != 2'd0) && ptr[15];
  lin = (mode != 2'd0) && !ptr[15] && (ptr >= `BDM_LIN_BASE)
        && (ptr <= `BDM_LIN_END);
  if (mode == 2'd0)
    addr = {bank_select, offset};
  else
    addr = ptr[11:0];
  lin_off = ptr - `BDM_LIN_BASE;
  lin_ofs = 8'h00;
end
assign bnk = addr[11:7];
assign ofs = addr[6:0];
always @* begin
  core_hit = !lin && (ofs <= `BDM_OFS_CORE_END);
  com_hit  = !lin && (ofs >= `BDM_OFS_COM_LO);
  gpr_hit  = lin || ((ofs >= `BDM_OFS_GPR_LO) &&
             (ofs <= `BDM_OFS_GPR_HI));
  if (lin)
    gidx = lin_off[11:0];
  else
    gidx = bnk * 12'd80 + {5'h00, ofs - `BDM_OFS_GPR_LO};
end
////////////////////////////////////////////////////////////////////////////
// read decode; peripheral slots and holes read zero
always @* begin
  rd_mux = 8'h00;
  if (core_hit) begin
    case (ofs)
      `BDM_OFS_PCL:    rd_mux = program_counter_low;
      `BDM_OFS_STATUS: rd_mux = {3'b000, status[4:0]};
      `BDM_OFS_PTR0L:  rd_mux = ptr0l;
      `BDM_OFS_PTR0H:  rd_mux = ptr0h;
      `BDM_OFS_PTR1L:  rd_mux = ptr1l;
      `BDM_OFS_PTR1H:  rd_mux = ptr1h;
      `BDM_OFS_BANK:   rd_mux = {3'b000, bank_select};
      `BDM_OFS_WORKING_ACCUMULATOR:   rd_mux = working_accumulator;
      `BDM_OFS_PROGRAM_COUNTER_LATCH_HIGH: rd_mux = program_counter_latch_high;
      `BDM_OFS_INTERRUPT_CONTROL: rd_mux = interrupt_control;
      default:         rd_mux = 8'h00;
    endcase
  end else if (com_hit)
    rd_mux = com_mem[ofs[3:0]];
  else if (gpr_hit)
    rd_mux = gpr_mem[gidx];
end
////////////////////////////////////////////////////////////////////////////
// alu flags
always @* begin
  b_eff = (alu_op == `BDM_OP_SUB) ? (~op_b) : op_b;
  sum = {1'b0, op_a} + {1'b0, b_eff} +
        {8'h00, (alu_op == `BDM_OP_SUB)};
  nib = {1'b0, op_a[3:0]} + {1'b0, b_eff[3:0]} +
        {4'h0, (alu_op == `BDM_OP_SUB)};
  next_status = status;
  case (alu_op)
    `BDM_OP_ADD, `BDM_OP_SUB: begin
      next_status[`BDM_BIT_C]  = sum[8];
      next_status[`BDM_BIT_DC] = nib[4];
      next_status[`BDM_BIT_Z]  = (sum[7:0] == 8'h00);
    end
    `BDM_OP_LOGIC:
      next_status[`BDM_BIT_Z] = (op_a == 8'h00);
    `BDM_OP_RLF:
      next_status[`BDM_BIT_C] = op_a[7];
    `BDM_OP_RRF:
      next_status[`BDM_BIT_C] = op_a[0];
    `BDM_OP_CLR: begin
      next_status[7:5] = 3'b000;
      next_status[`BDM_BIT_Z] = 1'b1;
    end
    default: next_status = status;
  endcase
end
////////////////////////////////////////////////////////////////////////////
// storage and status
always @(posedge clk or negedge arst_n) begin
  if (!arst_n) begin
    status      <= `BDM_STATUS_RST;
    bank_select <= 5'h00;
    ptr0l <= 8'h00;
    ptr0h <= 8'h00;
    ptr1l <= 8'h00;
    ptr1h <= 8'h00;
    working_accumulator <= 8'h00;
    program_counter_low <= 8'h00;
    program_counter_latch_high <= 8'h00;
    interrupt_control <= 8'h00;
    rdata <= 8'h00;
    rvalid <= 1'b0;
    prog_req <= 1'b0;
    prog_addr <= 15'h0000;
    prog_wait <= 1'b0;
    alu_result <= 8'h00;
    periph_addr_dummy <= 8'h00;
  end else begin
    rvalid <= 1'b0;
    prog_req <= 1'b0;
    alu_result <= sum[7:0];
    if (prog_wait) begin
      prog_wait <= 1'b0;
      rvalid <= 1'b1;
      rdata <= prog_rdata;
    end else if (req && !wr && prog_sel) begin
      prog_wait <= 1'b1;
      prog_req <= 1'b1;
      prog_addr <= ptr[14:0];
    end else if (req && !wr) begin
      rvalid <= 1'b1;
      rdata <= rd_mux;
    end
    if (req && wr && !prog_sel && !lin &&
        (ofs >= `BDM_OFS_PERI_LO) && (ofs <= `BDM_OFS_PERI_HI))
      periph_addr_dummy <= {1'b0, ofs};
    if (req && wr && !prog_sel && core_hit) begin
      case (ofs)
        `BDM_OFS_PCL:    program_counter_low <= wdata;
        `BDM_OFS_PTR0L:  ptr0l <= wdata;
        `BDM_OFS_PTR0H:  ptr0h <= wdata;
        `BDM_OFS_PTR1L:  ptr1l <= wdata;
        `BDM_OFS_PTR1H:  ptr1h <= wdata;
        `BDM_OFS_BANK:   bank_select <= wdata[4:0];
        `BDM_OFS_WORKING_ACCUMULATOR:   working_accumulator <= wdata;
        `BDM_OFS_PROGRAM_COUNTER_LATCH_HIGH: program_counter_latch_high <= wdata;
        `BDM_OFS_INTERRUPT_CONTROL: interrupt_control <= wdata;
        default:         program_counter_low <= program_counter_low;
      endcase
    end
    // status: hardware flags then write, events win
    begin : st
      reg [7:0] s;
      s = next_status;
      if (req && wr && !prog_sel && core_hit &&
          ofs == `BDM_OFS_STATUS) begin
        s[7:5] = 3'b000;
        if (alu_op == `BDM_OP_NONE)
          s[2:0] = wdata[2:0];
        else if (alu_op == `BDM_OP_RLF || alu_op == `BDM_OP_RRF)
          s[`BDM_BIT_Z] = wdata[`BDM_BIT_Z];
      end
      if (wdt_clear) begin
        s[`BDM_BIT_TO] = 1'b1;
        s[`BDM_BIT_PD] = 1'b1;
      end
      if (sleep_exec) begin
        s[`BDM_BIT_TO] = 1'b1;
        s[`BDM_BIT_PD] = 1'b0;
      end
      if (wdt_timeout)
        s[`BDM_BIT_TO] = 1'b0;
      status <= {3'b000, s[4:0]};
    end
  end
end
////////////////////////////////////////////////////////////////////////////
// ram arrays carry no reset
always @(posedge clk) begin
  if (req && wr && !prog_sel && com_hit)
    com_mem[ofs[3:0]] <= wdata;
  if (req && wr && !prog_sel && gpr_hit)
    gpr_mem[gidx] <= wdata;
end
endmodule // bdm_data_memory
`default_nettype wire

// file: verilog/bdm_regs.vh
// constants for the banked data memory and core status block
// assumes a single core clock and a core datapath driving the access port
`ifndef BDM_REGS_VH
`define BDM_REGS_VH
`define BDM_OFS_INDIRECT_PORT_ZERO     7'h00
`define BDM_OFS_INDIRECT_PORT_ONE     7'h01
`define BDM_OFS_PCL       7'h02
`define BDM_OFS_STATUS    7'h03
`define BDM_OFS_PTR0L     7'h04
`define BDM_OFS_PTR0H     7'h05
`define BDM_OFS_PTR1L     7'h06
`define BDM_OFS_PTR1H     7'h07
`define BDM_OFS_BANK      7'h08
`define BDM_OFS_WORKING_ACCUMULATOR      7'h09
`define BDM_OFS_PROGRAM_COUNTER_LATCH_HIGH    7'h0a
`define BDM_OFS_INTERRUPT_CONTROL    7'h0b
`define BDM_OFS_CORE_END  7'h0b
`define BDM_OFS_PERI_LO   7'h0c
`define BDM_OFS_PERI_HI   7'h1f
`define BDM_OFS_GPR_LO    7'h20
`define BDM_OFS_GPR_HI    7'h6f
`define BDM_OFS_COM_LO    7'h70
`define BDM_GPR_BYTES     80
`define BDM_GPR_BANKS     32
`define BDM_GPR_DEPTH     2560
`define BDM_LIN_BASE      16'h2000
`define BDM_LIN_END       16'h29ff
`define BDM_BIT_TO        4
`define BDM_BIT_PD        3
`define BDM_BIT_Z         2
`define BDM_BIT_DC        1
`define BDM_BIT_C         0
`define BDM_STATUS_RST    8'h18
`define BDM_OP_NONE       3'h0
`define BDM_OP_ADD        3'h1
`define BDM_OP_SUB        3'h2
`define BDM_OP_LOGIC      3'h3
`define BDM_OP_RLF        3'h4
`define BDM_OP_RRF        3'h5
`define BDM_OP_CLR        3'h6
`endif

// file: verification/bdm_prog_model.sv
// program memory seen through the pointer fetch port
// byte stands while the fetch request is up, for the next edge
`timescale 1ns/1ps
`default_nettype none
module bdm_prog_model (
  input  wire logic        clk,
  input  wire logic        prog_req,
  input  wire logic [14:0] prog_addr,
  output var  logic [7:0]  prog_rdata
);
  // byte from the address; other value when idle
  always_comb begin
    prog_rdata = prog_req ? (prog_addr[7:0] ^ 8'h5a) : ~prog_addr[7:0];
  end
endmodule // bdm_prog_model
`default_nettype wire

// file: verification/bdm_data_memory_chk.sv
// port assertions for the banked data memory
// bound to every instance of the data memory module
`timescale 1ns/1ps
`default_nettype none
`include "bdm_regs.vh"
module bdm_data_memory_chk (
  input wire logic       clk, arst_n, req, wr, rvalid, prog_req,
  input wire logic       wdt_clear, sleep_exec, wdt_timeout,
  input wire logic [1:0] mode,
  input wire logic [6:0] offset,
  input wire logic [2:0] alu_op,
  input wire logic [7:0] wdata, op_a, op_b, alu_result, status,
  input wire logic [4:0] bank_select
);
  logic [8:0] sum9;
  logic [4:0] nib;
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  always @(posedge clk) begin
    sum9 <= {1'b0, op_a} + {1'b0, op_b};
    nib  <= {1'b0, op_a[3:0]} + {1'b0, op_b[3:0]};
  end
  sequence s_bank_wr;
    req && wr && mode == 2'h0 && offset == `BDM_OFS_BANK;
  endsequence
  a_top_zero: assert property (status[7:5] == 3'h0)
    else $error("status top bits set");
  a_read_answer: assert property (req && !wr && mode == 2'h0
    && offset > 7'h01 |=> rvalid) else $error("read not answered");
  a_bank_write: assert property (s_bank_wr |=>
    bank_select == $past(wdata[4:0])) else $error("bank not taken");
  a_timeout_clear: assert property (wdt_timeout |=> !status[4])
    else $error("time-out flag kept");
  a_sleep_flags: assert property (sleep_exec && !wdt_timeout
    && !wdt_clear |=> status[4:3] == 2'h2) else $error("sleep flags");
  a_clear_flags: assert property (wdt_clear && !sleep_exec
    && !wdt_timeout |=> status[4:3] == 2'h3) else $error("clear flags");
  a_flag_hold: assert property (!wdt_clear && !sleep_exec
    && !wdt_timeout |=> $stable(status[4:3])) else $error("flags moved");
  a_prog_wait: assert property (prog_req |-> ##[1:2] rvalid)
    else $error("program read not answered");
  a_add_flags: assert property (alu_op == `BDM_OP_ADD |=>
    status[2:0] == {sum9[7:0] == 8'h00, nib[4], sum9[8]}
    && alu_result == sum9[7:0]) else $error("add flags wrong");
endmodule // bdm_data_memory_chk
bind bdm_data_memory bdm_data_memory_chk bdm_data_memory_chk_i (.clk,
  .arst_n, .req, .wr, .rvalid, .prog_req, .wdt_clear, .sleep_exec,
  .wdt_timeout, .mode, .offset, .alu_op, .wdata, .op_a, .op_b,
  .alu_result, .status, .bank_select);
`default_nettype wire

// file: verification/banked_data_memory_status_tb_top.sv
// self-checking bench for the banked data memory
// drives the core side; program memory comes from the model
`timescale 1ns/1ps
`default_nettype none
`include "bdm_regs.vh"
module banked_data_memory_status_tb_top;
  logic        clk = 0, arst_n = 0, req = 0, wr = 0, rvalid, prog_req;
  logic        wdt_clear = 0, sleep_exec = 0, wdt_timeout = 0;
  logic [1:0]  mode = 2'h0;
  logic [6:0]  offset = 7'h00;
  logic [2:0]  alu_op = 3'h0;
  logic [7:0]  wdata = 8'h00, op_a = 8'h00, op_b = 8'h00;
  logic [7:0]  prog_rdata, rdata, status, rd, pa;
  logic [14:0] prog_addr;
  logic [4:0]  bank_select;
  int          n_fail = 0, check_count = 0;
  always #5 clk = ~clk;
  bdm_data_memory bdm_data_memory_i (.clk, .arst_n, .req, .wr, .mode,
    .offset, .wdata, .alu_op, .op_a, .op_b, .alu_cin(1'b0), .wdt_clear,
    .sleep_exec, .wdt_timeout, .prog_rdata, .rdata, .rvalid, .prog_req,
    .prog_addr, .alu_result(), .status, .bank_select,
    .periph_addr_dummy(pa));
  bdm_prog_model bdm_prog_model_i (.clk, .prog_req, .prog_addr, .prog_rdata);
  //////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    check_count++;
    if (got !== exp) begin
      n_fail++;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic w, input logic [1:0] m,
      input logic [6:0] o, input logic [7:0] d, input logic [2:0] op = 3'h0);
    rd = 8'hxx;
    @(posedge clk); req <= 1; wr <= w; mode <= m; offset <= o; wdata <= d;
    alu_op <= op;
    @(posedge clk); req <= 0; alu_op <= 3'h0;
    for (int i = 0; i < 4; i++) begin
      #1; if (rvalid === 1'b1) begin rd = rdata; break; end
      @(posedge clk);
    end
  endtask
  task automatic ev(input logic [2:0] k, input logic [1:0] e);
    @(posedge clk); {wdt_clear, sleep_exec, wdt_timeout} <= k;
    @(posedge clk); {wdt_clear, sleep_exec, wdt_timeout} <= 3'h0;
    #1; chk({6'h00, status[4:3]}, {6'h00, e});
  endtask
  task automatic al(input logic [2:0] op, input logic [7:0] a, b, m, e);
    @(posedge clk); alu_op <= op; op_a <= a; op_b <= b;
    @(posedge clk); alu_op <= 3'h0;
    #1; chk(status & m, e);
  endtask
  //////////////////////////////////////////////////////////////////////////
  task automatic t_status();
    chk(status, 8'h18);
    acc(1, 2'h0, `BDM_OFS_STATUS, 8'hff); chk(status, 8'h1f);
    // status bits 2:0 written by a plain move; a rotate writes only Z, CLR and ADD writes none
    acc(1, 2'h0, `BDM_OFS_STATUS, 8'h00);
    acc(1, 2'h0, `BDM_OFS_STATUS, 8'h07); chk(status, 8'h1f);
    acc(1, 2'h0, `BDM_OFS_STATUS, 8'hff, `BDM_OP_CLR); chk(status, 8'h1f);
    acc(1, 2'h0, `BDM_OFS_STATUS, 8'h03, `BDM_OP_ADD); chk(status, 8'h1c);
    acc(0, 2'h0, `BDM_OFS_STATUS, 8'h00); chk(rd, 8'h1c);
    ev(3'h2, 2'h2);
    ev(3'h1, 2'h0);
    ev(3'h4, 2'h3);
  endtask
  task automatic t_banks();
    acc(1, 2'h0, `BDM_OFS_BANK, 8'h05); acc(1, 2'h0, 7'h20, 8'ha5);
    acc(1, 2'h0, 7'h70, 8'h3c); acc(1, 2'h0, `BDM_OFS_BANK, 8'h06);
    acc(1, 2'h0, 7'h20, 8'h5a);
    acc(0, 2'h0, 7'h70, 8'h00); chk(rd, 8'h3c);
    acc(0, 2'h0, `BDM_OFS_BANK, 8'h00); chk(rd, 8'h06);
    acc(0, 2'h0, 7'h20, 8'h00); chk(rd, 8'h5a);
    acc(1, 2'h0, `BDM_OFS_BANK, 8'h05);
    acc(0, 2'h0, 7'h20, 8'h00); chk(rd, 8'ha5);
    acc(1, 2'h0, 7'h0f, 8'h99); chk(pa, 8'h0f);
    acc(0, 2'h0, 7'h0f, 8'h00); chk(rd, 8'h00);
  endtask
  task automatic t_pointers();
    acc(1, 2'h0, `BDM_OFS_BANK, 8'h00); acc(1, 2'h0, 7'h25, 8'h77);
    acc(1, 2'h0, `BDM_OFS_PTR0H, 8'h20); acc(1, 2'h0, `BDM_OFS_PTR0L, 8'h05);
    acc(0, 2'h1, 7'h00, 8'h00); chk(rd, 8'h77);
    acc(1, 2'h0, `BDM_OFS_PTR0L, 8'h50); acc(1, 2'h1, 7'h00, 8'h42);
    acc(1, 2'h0, `BDM_OFS_BANK, 8'h01);
    acc(0, 2'h0, 7'h20, 8'h00); chk(rd, 8'h42);
    acc(1, 2'h0, `BDM_OFS_PTR1H, 8'h81); acc(1, 2'h0, `BDM_OFS_PTR1L, 8'h23);
    acc(0, 2'h2, 7'h01, 8'h00); chk(rd, 8'h79);
  endtask
  task automatic t_alu();
    al(`BDM_OP_ADD, 8'h0f, 8'h01, 8'h07, 8'h02);
    al(`BDM_OP_ADD, 8'hff, 8'h01, 8'h07, 8'h07);
    al(`BDM_OP_SUB, 8'h05, 8'h05, 8'h07, 8'h07);
    al(`BDM_OP_SUB, 8'h03, 8'h05, 8'h07, 8'h00);
    al(`BDM_OP_LOGIC, 8'h00, 8'h00, 8'h04, 8'h04);
    al(`BDM_OP_RLF, 8'h80, 8'h00, 8'h01, 8'h01);
    al(`BDM_OP_RRF, 8'h01, 8'h00, 8'h01, 8'h01);
    al(`BDM_OP_RLF, 8'h01, 8'h00, 8'h01, 8'h00);
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  initial begin
    repeat (10) @(posedge clk);
    arst_n <= 1;
    t_status();
    t_banks();
    t_pointers();
    t_alu();
    tally_and_finish();
  end
  initial begin
    #100000;
    n_fail++;
    tally_and_finish();
  end
endmodule // banked_data_memory_status_tb_top
`default_nettype wire
